// ### hdl/sfm_bus_ctrl.sv
// serial flash bus mode front end: framing, lanes, pause, resets, write gating
// Notes on behaviour
// R1: single-line input on lane 0, taken at clock rise.
// R2: single-line output on lane 1, changed at clock fall.
// R3: clock modes 0 and 3 work; only clock edges matter.
// R4: dual reads turn lanes 0 and 1 bidirectional.
// R5: quad reads use four lanes, only with quad enable.
// R6: opcode in two clocks in four-wire mode, eight in SPI.
// R7: enter opcode selects four-wire mode, exit returns to SPI.
// R8: power-up and software reset leave the device in SPI mode.
// R9: four-wire entry ignored unless quad enable set.
// R10: pause only in standard/dual use with quad enable clear.
// R11: pause starts at pause fall if clock low, else after next clock fall.
// R12: pause ends at pause rise if clock low, else after next clock fall.
// R13: paused: lanes float, clock and input ignored, state kept.
// R14: host keeps select low while paused; raising it resets the frame.
// R15: reset-enable then reset: 28 us reset, all commands refused.
// R16: pin function bit: 0 pause input, 1 active-low reset.
// R17: reset pin low 1 us clears mode, power-down, arming and latch, aborts work, blocks commands.
// R18: write-type commands refused until power-up delay ends.
// R19: latch clear at power-up; writes need write-enable first.
// R20: finished program, erase or status write clears the latch.
// R21: in power-down only the release opcode is accepted.
// R22: status write gated by protect bits, latch and, in SPI, protect pin.
// R23: protect bits 0,1 lock status on low protect pin; 0,0 ignore pin.
// R24: quad enable is status bit 9.
// R25: select rise floats lanes, drops partial opcode, waits for next fall.
`timescale 1ns/100ps
`default_nettype none
`include "sfm_map.svh"

module sfm_bus_ctrl #(
    parameter int unsigned SOFT_RESET_CYCLES =
        (`SFM_SOFT_RESET_NS + `SFM_CLK_PERIOD_NS - 1) / `SFM_CLK_PERIOD_NS,
    parameter int unsigned POWERUP_CYCLES = 1000,
    parameter logic [7:0] WREN_OP = 8'h10,
    parameter logic [7:0] WRDI_OP = 8'h11,
    parameter logic [7:0] WRSR_OP = 8'h12,
    parameter logic [7:0] PROG_OP = 8'h13,
    parameter logic [7:0] SECT_ERASE_OP = 8'h14,
    parameter logic [7:0] BLK32_ERASE_OP = 8'h15,
    parameter logic [7:0] BLK64_ERASE_OP = 8'h16,
    parameter logic [7:0] CHIP_ERASE_OP = 8'h17,
    parameter logic [7:0] POWER_DOWN_OP = 8'h18,
    parameter logic [7:0] RELEASE_PD_OP = 8'h19
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic sclk_i,
    input wire logic cs_b_i,
    input wire logic [3:0] lane_i,
    output var logic [3:0] lane_o,
    output var logic [3:0] lane_oe_o,
    input wire logic [15:0] status_reg_i,
    input wire logic hold_reset_sel_i,
    input wire logic out_phase_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output wire logic tx_ready_o,
    input wire logic op_done_i,
    output var logic [7:0] cmd_o,
    output var logic cmd_valid_o,
    output var logic cmd_reject_o,
    output var logic [7:0] rx_byte_o,
    output var logic rx_byte_valid_o,
    output var logic frame_end_o,
    output var logic four_wire_instruction_mode_o,
    output var logic write_enable_latch_o,
    output var logic paused_o,
    output var logic power_down_o,
    output var logic reset_busy_o,
    output var logic write_inhibit_o,
    output var logic abort_o
);

    import sfm_pkg::*;

    localparam int unsigned HW_RESET_CYCLES =
        (`SFM_HW_RESET_NS + `SFM_CLK_PERIOD_NS - 1) / `SFM_CLK_PERIOD_NS;

    logic [5:0] pins;
    logic sclk_f;
    logic cs_b_f;
    logic [3:0] lanes_f;
    logic sclk_d;
    logic cs_d;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic rise_ok;
    logic fall_ok;
    logic qe;
    logic pin3_is_hold;
    logic pin3_is_reset;
    logic hw_rst_low;
    logic [8:0] hw_cnt;
    logic hw_hit;
    logic [15:0] sr_cnt;
    logic [15:0] pu_cnt;
    logic rst_armed;
    sfm_phase_e phase;
    sfm_width_e in_w;
    sfm_width_e out_w;
    sfm_width_e next_in_w;
    sfm_width_e next_out_w;
    logic ign;
    logic [7:0] rx_sr;
    logic [7:0] next_sr;
    logic [3:0] rx_cnt;
    logic [3:0] next_cnt;
    logic opc_done;
    logic op_ok;
    logic sr_unlocked;
    logic soft_start;
    logic dev_clear;
    logic out_active;
    logic tx_pop;
    logic [7:0] tx_sr;
    logic [3:0] tx_cnt;
    logic [7:0] fifo_data;
    logic fifo_valid;
    logic [7:0] load_byte;

    // bits moved per clock for a lane width
    function automatic logic [3:0] step_of(input sfm_width_e w);
        unique case (w)
            SFM_W2: step_of = 4'h2;
            SFM_W4: step_of = 4'h4;
            default: step_of = 4'h1;
        endcase
    endfunction : step_of

    // lanes driven for a width; single-line reads use lane 1 only
    function automatic logic [3:0] oe_of(input sfm_width_e w);
        unique case (w)
            SFM_W2: oe_of = 4'h3;
            SFM_W4: oe_of = 4'hF;
            default: oe_of = 4'h2;
        endcase
    endfunction : oe_of

    // top bits of a byte on the lanes, msb first
    function automatic logic [3:0] put_of(input logic [7:0] b, input sfm_width_e w);
        unique case (w)
            SFM_W2: put_of = {2'h0, b[7], b[6]};
            SFM_W4: put_of = b[7:4];
            default: put_of = {2'h0, b[7], 1'b0};
        endcase
    endfunction : put_of

    // host pins pass the filter first
    sfm_sync #(
        .WIDTH(6),
        .RESET_VAL(`SFM_PIN_RESET)
    ) u_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .async_i({sclk_i, cs_b_i, lane_i}),
        .stable_o(pins)
    );

    // read data queue to the output shifter
    sfm_fifo #(
        .WIDTH(`SFM_FIFO_WIDTH),
        .DEPTH(`SFM_FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .in_valid_i(tx_valid_i),
        .in_ready_o(tx_ready_o),
        .in_data_i(tx_data_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(tx_pop),
        .out_data_o(fifo_data)
    );

    assign sclk_f = pins[5];
    assign cs_b_f = pins[4];
    assign lanes_f = pins[3:0];
    assign qe = status_reg_i[`SFM_QE_POS]; // R24
    assign pin3_is_hold = !qe && !hold_reset_sel_i; // R16
    assign pin3_is_reset = !qe && hold_reset_sel_i; // R16
    assign hw_rst_low = pin3_is_reset && !lanes_f[3];
    assign hw_hit = hw_rst_low && hw_cnt == 9'(HW_RESET_CYCLES - 1);

    // edges only, so the idle clock level does not matter
    assign sclk_rise = sclk_f && !sclk_d; // R3
    assign sclk_fall = !sclk_f && sclk_d; // R3
    assign cs_fall = !cs_b_f && cs_d;
    assign cs_rise = cs_b_f && !cs_d;
    assign rise_ok = sclk_rise && !paused_o && !cs_b_f; // R13
    assign fall_ok = sclk_fall && !paused_o && !cs_b_f; // R13

    // edge history
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sclk_d <= 1'b0;
            cs_d <= 1'b1;
        end
        else if (ce_i)
        begin
            sclk_d <= sclk_f;
            cs_d <= cs_b_f;
        end
    end

    // input shifter; width follows the phase and the opcode
    always_comb
    begin
        next_cnt = rx_cnt + step_of(in_w);
        unique case (in_w)
            SFM_W2: next_sr = {rx_sr[5:0], lanes_f[1:0]}; // R4
            SFM_W4: next_sr = {rx_sr[3:0], lanes_f}; // R5 R6
            default: next_sr = {rx_sr[6:0], lanes_f[0]}; // R1
        endcase
    end

    assign opc_done = phase == SFM_OPC && rise_ok && next_cnt[3];

    // protect bits 1x lock for good; 01 consults the pin only in SPI use
    always_comb
    begin
        unique case ({status_reg_i[`SFM_SRP_HI_POS], status_reg_i[`SFM_SRP_LO_POS]})
            2'h0: sr_unlocked = 1'b1; // R23
            2'h1: sr_unlocked = qe || four_wire_instruction_mode_o || lanes_f[2]; // R22 R23
            default: sr_unlocked = 1'b0; // R22
        endcase
    end

    // opcode acceptance and body lane widths
    always_comb
    begin
        op_ok = 1'b1;
        next_in_w = four_wire_instruction_mode_o ? SFM_W4 : SFM_W1;
        next_out_w = next_in_w;
        if (hw_rst_low || reset_busy_o)
            op_ok = 1'b0; // R15 R17
        else if (power_down_o && next_sr != RELEASE_PD_OP)
            op_ok = 1'b0; // R21
        else
        begin
            case (next_sr)
                `SFM_OP_DUAL_OUT:
                    if (!four_wire_instruction_mode_o)
                        next_out_w = SFM_W2; // R4
                `SFM_OP_DUAL_IO:
                    if (!four_wire_instruction_mode_o)
                    begin
                        next_in_w = SFM_W2; // R4
                        next_out_w = SFM_W2;
                    end
                `SFM_OP_QUAD_OUT:
                begin
                    op_ok = qe; // R5
                    next_out_w = SFM_W4;
                end
                `SFM_OP_QUAD_IO, `SFM_OP_WORD_QUAD_IO:
                begin
                    op_ok = qe; // R5
                    next_in_w = SFM_W4;
                    next_out_w = SFM_W4;
                end
                `SFM_OP_ENTER_FOUR_WIRE: op_ok = qe && !four_wire_instruction_mode_o; // R7 R9
                `SFM_OP_RESET: op_ok = rst_armed; // R15
                WREN_OP: op_ok = !write_inhibit_o; // R18
                WRSR_OP: op_ok = !write_inhibit_o && write_enable_latch_o && sr_unlocked; // R22
                PROG_OP, SECT_ERASE_OP, BLK32_ERASE_OP, BLK64_ERASE_OP, CHIP_ERASE_OP:
                    op_ok = !write_inhibit_o && write_enable_latch_o; // R18 R19
                default: ;
            endcase
        end
    end

    assign soft_start = opc_done && op_ok && next_sr == `SFM_OP_RESET;
    assign dev_clear = soft_start || hw_hit;

    // frame sequencing; select high drops any partial opcode
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            phase <= SFM_IDLE;
            rx_sr <= `SFM_BYTE_RESET;
            rx_cnt <= 4'h0;
            in_w <= SFM_W1;
            out_w <= SFM_W1;
            ign <= 1'b0;
            cmd_o <= `SFM_BYTE_RESET;
            cmd_valid_o <= 1'b0;
            cmd_reject_o <= 1'b0;
            rx_byte_o <= `SFM_BYTE_RESET;
            rx_byte_valid_o <= 1'b0;
            frame_end_o <= 1'b0;
        end
        else if (ce_i)
        begin
            cmd_valid_o <= 1'b0;
            cmd_reject_o <= 1'b0;
            rx_byte_valid_o <= 1'b0;
            frame_end_o <= cs_rise;
            if (cs_b_f)
            begin
                phase <= SFM_IDLE; // R14 R25
                rx_cnt <= 4'h0;
            end
            else
            begin
                unique case (phase)
                    SFM_IDLE:
                        if (cs_fall)
                        begin
                            phase <= SFM_OPC; // R25
                            ign <= 1'b0;
                            in_w <= four_wire_instruction_mode_o ? SFM_W4 : SFM_W1; // R6
                        end
                    SFM_OPC:
                        if (rise_ok)
                        begin
                            rx_sr <= next_sr;
                            rx_cnt <= next_cnt[3] ? 4'h0 : next_cnt;
                            if (next_cnt[3])
                            begin
                                phase <= SFM_BODY;
                                cmd_o <= next_sr;
                                cmd_valid_o <= op_ok;
                                cmd_reject_o <= !op_ok;
                                ign <= !op_ok;
                                in_w <= next_in_w;
                                out_w <= next_out_w;
                            end
                        end
                    SFM_BODY:
                        if (rise_ok && !out_phase_i)
                        begin
                            rx_sr <= next_sr;
                            rx_cnt <= next_cnt[3] ? 4'h0 : next_cnt;
                            if (next_cnt[3])
                            begin
                                rx_byte_o <= next_sr;
                                rx_byte_valid_o <= !ign;
                            end
                        end
                    default: phase <= SFM_IDLE;
                endcase
            end
        end
    end

    // pause tracks the pin while the clock is low; else it waits for a fall
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            paused_o <= 1'b0;
        else if (ce_i)
        begin
            if (cs_b_f || !pin3_is_hold || four_wire_instruction_mode_o)
                paused_o <= 1'b0; // R10 R14
            else if (!sclk_f)
                paused_o <= !lanes_f[3]; // R11 R12
        end
    end

    // bus mode, power-down and reset arming
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            four_wire_instruction_mode_o <= 1'b0; // R8
            power_down_o <= 1'b0;
            rst_armed <= 1'b0;
        end
        else if (ce_i)
        begin
            if (dev_clear)
            begin
                four_wire_instruction_mode_o <= 1'b0; // R8 R17
                power_down_o <= 1'b0;
                rst_armed <= 1'b0;
            end
            else if (opc_done && op_ok)
            begin
                rst_armed <= next_sr == `SFM_OP_RESET_ENABLE; // R15
                if (next_sr == `SFM_OP_ENTER_FOUR_WIRE)
                    four_wire_instruction_mode_o <= 1'b1; // R7
                else if (next_sr == `SFM_OP_EXIT_FOUR_WIRE)
                    four_wire_instruction_mode_o <= 1'b0; // R7
                if (next_sr == POWER_DOWN_OP)
                    power_down_o <= 1'b1;
                else if (next_sr == RELEASE_PD_OP)
                    power_down_o <= 1'b0; // R21
            end
            else if (opc_done)
                rst_armed <= 1'b0; // R15
        end
    end

    // write-enable latch; a set in the completion cycle wins
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            write_enable_latch_o <= 1'b0; // R19
        else if (ce_i)
        begin
            if (dev_clear)
                write_enable_latch_o <= 1'b0; // R17
            else if (opc_done && op_ok && next_sr == WREN_OP)
                write_enable_latch_o <= 1'b1; // R19
            else if (op_done_i || (opc_done && op_ok && next_sr == WRDI_OP))
                write_enable_latch_o <= 1'b0; // R20
        end
    end

    // timers: reset pin width, software reset, power-up delay
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            hw_cnt <= 9'h000;
            abort_o <= 1'b0;
            sr_cnt <= 16'h0000;
            reset_busy_o <= 1'b0;
            pu_cnt <= 16'h0000;
            write_inhibit_o <= 1'b1; // R18
        end
        else if (ce_i)
        begin
            abort_o <= hw_hit; // R17
            if (!hw_rst_low)
                hw_cnt <= 9'h000;
            else if (hw_cnt != 9'(HW_RESET_CYCLES))
                hw_cnt <= hw_cnt + 9'h001; // R17
            if (soft_start)
            begin
                reset_busy_o <= 1'b1; // R15
                sr_cnt <= 16'h0000;
            end
            else if (reset_busy_o)
            begin
                sr_cnt <= sr_cnt + 16'h0001;
                if (sr_cnt == 16'(SOFT_RESET_CYCLES - 1))
                    reset_busy_o <= 1'b0; // R15
            end
            if (write_inhibit_o)
            begin
                pu_cnt <= pu_cnt + 16'h0001;
                if (pu_cnt == 16'(POWERUP_CYCLES - 1))
                    write_inhibit_o <= 1'b0; // R18
            end
        end
    end

    // output shifter; a new byte is pulled only when the last is spent
    assign out_active = !cs_b_f && out_phase_i && phase == SFM_BODY && !ign;
    assign tx_pop = out_active && fall_ok && tx_cnt == 4'h0;
    assign load_byte = fifo_valid ? fifo_data : `SFM_BYTE_RESET; // underrun sends zeros

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            lane_o <= 4'h0;
            lane_oe_o <= 4'h0;
            tx_sr <= `SFM_BYTE_RESET;
            tx_cnt <= 4'h0;
        end
        else if (ce_i)
        begin
            if (!out_active)
            begin
                lane_oe_o <= 4'h0; // R25
                tx_cnt <= 4'h0;
            end
            else
            begin
                lane_oe_o <= paused_o ? 4'h0 : oe_of(out_w); // R4 R5 R13
                if (fall_ok && tx_cnt == 4'h0)
                begin
                    lane_o <= put_of(load_byte, out_w); // R2
                    tx_sr <= load_byte << step_of(out_w);
                    tx_cnt <= 4'h8 - step_of(out_w);
                end
                else if (fall_ok)
                begin
                    lane_o <= put_of(tx_sr, out_w); // R2
                    tx_sr <= tx_sr << step_of(out_w);
                    tx_cnt <= tx_cnt - step_of(out_w);
                end
            end
        end
    end

endmodule : sfm_bus_ctrl

`default_nettype wire

// ### hdl/sfm_fifo.sv
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
`include "sfm_map.svh"

module sfm_fifo #(
    parameter int unsigned WIDTH = `SFM_FIFO_WIDTH,
    parameter int unsigned DEPTH = `SFM_FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    output var logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output var logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    assign out_data_o = mem[rd_ptr];

    // occupancy; flags are registered so the ports come from flops
    always_comb
    begin
        next_count = count;
        if (push && !pop)
            next_count = count + (AW+1)'(1);
        else if (pop && !push)
            next_count = count - (AW+1)'(1);
    end

    // storage, written only by an accepted push
    always_ff @(posedge clk_i)
    begin
        if (ce_i && push)
            mem[wr_ptr] <= in_data_i;
    end

    // pointers and flags; depth is a power of two so pointers wrap freely
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready_o <= 1'b1;
            out_valid_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (push)
                wr_ptr <= wr_ptr + AW'(1);
            if (pop)
                rd_ptr <= rd_ptr + AW'(1);
            count <= next_count;
            in_ready_o <= next_count != (AW+1)'(DEPTH);
            out_valid_o <= next_count != '0;
        end
    end

endmodule : sfm_fifo

`default_nettype wire

// ### hdl/sfm_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none

module sfm_sync #(
    parameter int unsigned WIDTH = 6,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] async_i,
    output var logic [WIDTH-1:0] stable_o
);

    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] agree;

    // only the second and third stages are compared; the first is metastable
    assign agree = ~(s2 ^ s3);

    // shift chain, stable value moves only where the late stages agree
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s1 <= RESET_VAL;
            s2 <= RESET_VAL;
            s3 <= RESET_VAL;
            stable_o <= RESET_VAL;
        end
        else if (ce_i)
        begin
            s1 <= async_i;
            s2 <= s1;
            s3 <= s2;
            stable_o <= (stable_o & ~agree) | (s3 & agree);
        end
    end

endmodule : sfm_sync

`default_nettype wire

// ### inc/sfm_map.svh
// constants for the serial flash bus mode front end
`ifndef SFM_MAP_SVH
`define SFM_MAP_SVH

// opcodes that change lane usage or bus mode, plus the reset-enable and reset pair
`define SFM_OP_DUAL_OUT 8'h3B
`define SFM_OP_DUAL_IO 8'hBB
`define SFM_OP_QUAD_OUT 8'h6B
`define SFM_OP_QUAD_IO 8'hEB
`define SFM_OP_WORD_QUAD_IO 8'hE7
`define SFM_OP_ENTER_FOUR_WIRE 8'h38
`define SFM_OP_EXIT_FOUR_WIRE 8'hFF
`define SFM_OP_RESET_ENABLE 8'h66
`define SFM_OP_RESET 8'h99

// status word bit positions
`define SFM_QE_POS 9
`define SFM_SRP_HI_POS 8
`define SFM_SRP_LO_POS 7

// timing
`define SFM_CLK_PERIOD_NS 5
`define SFM_SOFT_RESET_NS 28000
`define SFM_HW_RESET_NS 1000

// read data buffer
`define SFM_FIFO_WIDTH 8
`define SFM_FIFO_DEPTH 32

// reset values
`define SFM_PIN_RESET 6'h1F
`define SFM_BYTE_RESET 8'h00

`endif

// ### inc/sfm_pkg.sv
// types shared by the serial flash bus mode front end
package sfm_pkg;

    // lanes carrying one transfer direction
    typedef enum logic [1:0] {
        SFM_W1 = 2'h0,
        SFM_W2 = 2'h1,
        SFM_W4 = 2'h2
    } sfm_width_e;

    // frame phase
    typedef enum logic [1:0] {
        SFM_IDLE = 2'h0,
        SFM_OPC = 2'h1,
        SFM_BODY = 2'h2
    } sfm_phase_e;

endpackage : sfm_pkg

// ### verification/sfm_bus_ctrl_bench.sv
// self-checking bench for the flash bus mode front end
`timescale 1ns/100ps
`default_nettype none
module sfm_bus_ctrl_bench;
    logic clk_i = 1'b0, rst_b_i = 1'b0, out_phase_i = 1'b0, op_done_i = 1'b0, tx_valid_i = 1'b0;
    logic sclk_i, cs_b_i, tx_ready_o, cmd_reject_o, reset_busy_o, fw, write_enable_latch, inh;
    logic [3:0] drv, lane_o, lane_oe_o;
    logic [7:0] tx_data_i = 8'h00, r;
    logic [15:0] status_reg_i = 16'h0000;
    int num_errors = 0, checks = 0, rej = 0, busy = 0, k;
    // a released lane shows the host level, high when idle
    wire logic [3:0] lane_i = lane_oe_o & lane_o | ~lane_oe_o & drv;
    always #2.5 clk_i = ~clk_i;
    // refusals and reset cycles counted at each rising edge
    always @(posedge clk_i) rej += cmd_reject_o;
    always @(posedge clk_i) busy += reset_busy_o;
    sfm_host i_sfm_host (.sclk_o(sclk_i), .cs_b_o(cs_b_i), .drv_o(drv), .lane_i);
    sfm_bus_ctrl #(.SOFT_RESET_CYCLES(200), .POWERUP_CYCLES(150)) i_sfm_bus_ctrl (.clk_i,
        .rst_b_i, .ce_i(1'b1), .sclk_i, .cs_b_i, .lane_i, .lane_o, .lane_oe_o, .status_reg_i,
        .hold_reset_sel_i(1'b0), .out_phase_i, .tx_data_i, .tx_valid_i, .tx_ready_o, .op_done_i,
        .cmd_o(), .cmd_valid_o(), .cmd_reject_o, .rx_byte_o(), .rx_byte_valid_o(),
        .frame_end_o(), .four_wire_instruction_mode_o(fw), .write_enable_latch_o(write_enable_latch),
        .paused_o(), .power_down_o(), .reset_busy_o, .write_inhibit_o(inh), .abort_o());
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e)
            num_errors++;
        if (g !== e)
            $display("FAIL %0t got %h want %h", $time, g, e);
    endtask : cmp
    task automatic summarize;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    task automatic t_write;
        cmp({inh, write_enable_latch, fw}, 8'h04);
        k = rej;
        i_sfm_host.frame(8'h10, 1, 0, r);
        cmp(8'(rej - k), 8'h01);
        i_sfm_host.frame(8'h10, 1, 0, r);
        cmp(write_enable_latch, 8'h01);
        @(posedge clk_i);
        op_done_i <= 1'b1;
        @(posedge clk_i);
        op_done_i <= 1'b0;
        #20 cmp(write_enable_latch, 8'h00);
        $display("write done");
    endtask : t_write
    // fill the buffer until full, then drain it in one read
    task automatic t_read;
        @(posedge clk_i);
        tx_valid_i <= 1'b1;
        tx_data_i <= 8'hA0;
        k = 0;
        repeat (40)
        begin
            @(posedge clk_i);
            if (tx_ready_o === 1'b1)
                tx_data_i <= 8'hA1 + 8'(k++);
        end
        tx_valid_i <= 1'b0;
        cmp({tx_ready_o, 7'(k)}, 8'h20);
        out_phase_i <= 1'b1;
        i_sfm_host.frame(8'h03, 1, 32, r);
        cmp(r, 8'hBF);
        @(posedge clk_i);
        out_phase_i <= 1'b0;
        cmp(tx_ready_o, 8'h01);
        $display("read done");
    endtask : t_read
    task automatic t_mode;
        k = rej;
        i_sfm_host.frame(8'h38, 1, 0, r);
        cmp({fw, 7'(rej - k)}, 8'h01);
        @(posedge clk_i);
        status_reg_i <= 16'h0200;
        i_sfm_host.frame(8'h38, 1, 0, r);
        cmp(fw, 8'h01);
        i_sfm_host.frame(8'h66, 4, 0, r);
        i_sfm_host.frame(8'h99, 4, 0, r);
        k = rej;
        i_sfm_host.frame(8'h10, 1, 0, r);
        cmp(8'(rej - k), 8'h01);
        for (k = 0; reset_busy_o !== 1'b0 && k < 400; k++)
            @(posedge clk_i);
        cmp(8'(k / 400), 8'h00);
        cmp(8'(busy), 8'hC8);
        cmp(fw, 8'h00);
        $display("mode done");
    endtask : t_mode
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        t_write();
        t_read();
        t_mode();
        summarize();
    end
endmodule : sfm_bus_ctrl_bench
`default_nettype wire

// ### verification/sfm_bus_ctrl_chk.sv
// port assertions for the flash bus mode front end
`timescale 1ns/100ps
`default_nettype none
module sfm_bus_ctrl_chk #(
    parameter logic [7:0] WREN_OP = 8'h10
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic cs_b_i,
    input wire logic [15:0] status_reg_i,
    input wire logic op_done_i,
    input wire logic [3:0] lane_oe_o,
    input wire logic [7:0] cmd_o,
    input wire logic cmd_valid_o,
    input wire logic four_wire_instruction_mode_o,
    input wire logic write_enable_latch_o,
    input wire logic reset_busy_o,
    input wire logic write_inhibit_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    // short aliases keep each check on one line
    wire logic fw = four_wire_instruction_mode_o;
    wire logic write_enable_latch = write_enable_latch_o;
    // deselect takes a few clocks through the synchroniser
    sequence s_idle;
        cs_b_i [*8];
    endsequence
    a_idle_float: assert property (s_idle |-> lane_oe_o == 4'h0) else $error("drive");
    a_enter_qe: assert property ($rose(fw) |-> cmd_o == 8'h38 && status_reg_i[9]) else $error("qe");
    a_busy_cause: assert property ($rose(reset_busy_o) |-> cmd_o == 8'h99) else $error("rst");
    a_busy_mute: assert property ($past(reset_busy_o) |-> !cmd_valid_o) else $error("busy");
    a_reset_spi: assert property ($fell(reset_busy_o) |-> !fw) else $error("mode");
    a_latch_set: assert property ($rose(write_enable_latch) |-> cmd_o == WREN_OP && !write_inhibit_o) else $error("wel");
    a_done_clear: assert property (op_done_i |=> !write_enable_latch || cmd_valid_o && cmd_o == WREN_OP) else $error("clr");
    a_oe_single: assert property (lane_oe_o != 4'h0 && cmd_o == 8'h03 && !fw |-> lane_oe_o == 4'h2) else $error("oe");
endmodule : sfm_bus_ctrl_chk
bind sfm_bus_ctrl sfm_bus_ctrl_chk #(.WREN_OP(WREN_OP)) i_sfm_bus_ctrl_chk (.clk_i, .rst_b_i,
    .cs_b_i, .status_reg_i, .op_done_i, .lane_oe_o, .cmd_o, .cmd_valid_o,
    .four_wire_instruction_mode_o, .write_enable_latch_o, .reset_busy_o, .write_inhibit_o);
`default_nettype wire

// ### verification/sfm_host.sv
// host bus master model for the flash pins
`timescale 1ns/100ps
`default_nettype none
module sfm_host (
    output var logic sclk_o,
    output var logic cs_b_o,
    output var logic [3:0] drv_o,
    input wire logic [3:0] lane_i
);
    // mode 0 idle, lanes left high as a pull-up would
    initial {sclk_o, cs_b_o, drv_o} = 6'h1F;
    // opcode on w lanes, n body bytes; r sampled just before each fall
    task automatic frame(input logic [7:0] op, input int w, input int n, output logic [7:0] r);
        cs_b_o = 1'b0;
        #48;
        for (int i = 0; i < 8 * n + 8; i += w)
        begin
            drv_o = i > 7 ? 4'hF : w == 4 ? op[7 - i -: 4] : {3'h7, op[7 - i]};
            #24 sclk_o = 1'b1;
            #24 r = w == 4 ? {r[3:0], lane_i} : {r[6:0], lane_i[1]};
            sclk_o = 1'b0;
        end
        #48 drv_o = 4'hF;
        cs_b_o = 1'b1;
        #96;
    endtask : frame
endmodule : sfm_host
`default_nettype wire
